// ===== inc/hpfc_pkg.sv
package hpfc_pkg;

	localparam int LANES = 4;

	// rounding override encodings
	localparam logic [1:0] RND_NEAREST = 2'h0;
	localparam logic [1:0] RND_DOWN    = 2'h1;
	localparam logic [1:0] RND_UP      = 2'h2;
	localparam logic [1:0] RND_TRUNC   = 2'h3;

	// immediate byte fields
	localparam int IMM_RND_LSB = 0;
	localparam int IMM_SRC_BIT = 2;

	// float field constants
	localparam logic [7:0]  EXP8_ALL1   = 8'hff;
	localparam logic [4:0]  EXP5_ALL1   = 5'h1f;
	localparam int          NAN_DROP    = 14;
	localparam logic [9:0]  HALF_BIAS_D = 10'h070;
	localparam logic [17:0] HALF_OVF    = 18'h07c00;
	localparam logic [7:0]  H2S_REBIAS  = 8'h70;
	localparam logic [7:0]  H2S_DEN_EXP = 8'h67;

	// identification result bits
	localparam int FEAT_HALF_CONV_BIT = 29;
	localparam int FEAT_VEC256_BIT    = 28;

	localparam logic [4:0] FLAGS_RESET = 5'h00;

	typedef struct packed {
		logic inv;
		logic den;
		logic unf;
		logic ovf;
		logic prc;
	} hpfc_flags_t;

	typedef struct packed {
		logic [1:0]  rnd_mode;
		hpfc_flags_t mask;
	} hpfc_ctl_t;

	typedef struct packed {
		logic [15:0] res;
		hpfc_flags_t flg;
	} hpfc_half_t;

	typedef struct packed {
		logic [31:0] res;
		hpfc_flags_t flg;
	} hpfc_single_t;

endpackage

// ===== hw/hpfc_convert.sv
`timescale 1ns/1ps
// Overview of operation
// [RL1] imm bit2 picks override or control rounding
// [RL2] override codes: nearest, down, up, truncate
// [RL3] no half arithmetic; conversions still flag
// [RL4] nan to half: sign, all-ones, drop 14; the code keeps m[22:13] and drops 13 low bits
// [RL5] signaling nan becomes quiet; quiet silent
// [RL6] signaling nan sets invalid; unmasked suppresses write
// [RL7] denormal flag on single-to-half only
// [RL8] below 2^-14 sets underflow, delivers rounded
// [RL9] flush-to-zero ignored in single-to-half
// [RL10] at least 2^16 overflows; masked gives infinity
// [RL11] inexact sets precision, returns rounded result
// [RL12] unmasked precision keeps masked overflow/underflow results
// [RL13] masked denormal plus unmasked precision/underflow raises
// [RL14] feature bits 29 and 28 advertised
// [RL15] imm bits 7:3 ignored; lanes accumulate flags
module hpfc_convert (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// request from the pipeline
	input  wire logic                 in_valid,
	input  wire logic                 in_to_half,
	input  wire logic [7:0]           in_imm,
	input  wire logic [127:0]         in_data,
	// control/status register fields
	input  wire hpfc_pkg::hpfc_ctl_t  csr_ctl,
	input  wire logic                 status_clr,
	// result
	output logic                      out_valid,
	output logic [127:0]              out_data,
	output logic                      out_write,
	output logic                      out_raise,
	output hpfc_pkg::hpfc_flags_t     out_flags,
	output hpfc_pkg::hpfc_flags_t     status_flags,
	output logic [31:0]               feature_ecx
);

	function automatic hpfc_pkg::hpfc_half_t s2h(input logic [31:0] x, input logic [1:0] rmode);
		logic              s;
		logic [7:0]        e;
		logic [22:0]       m;
		logic [23:0]       sig;
		logic signed [9:0] he;
		logic signed [9:0] t;
		logic [5:0]        sh;
		logic [49:0]       ext;
		logic [10:0]       keep;
		logic              g;
		logic              st;
		logic              inc;
		logic [11:0]       rnd;
		logic [17:0]       mag;
		hpfc_pkg::hpfc_half_t r;
		s = x[31];
		e = x[30:23];
		m = x[22:0];
		r = '0;
		if (e == hpfc_pkg::EXP8_ALL1) begin
			if (m != 23'h0) begin
				// [RL4] nan repack
				r.res = {s, hpfc_pkg::EXP5_ALL1, m[22:hpfc_pkg::NAN_DROP - 1]};
				// [RL5] [RL6] quiet it, flag invalid
				if (!m[22]) begin
					r.res[9] = 1'b1;
					r.flg.inv = 1'b1;
				end
			end else begin
				r.res = {s, hpfc_pkg::EXP5_ALL1, 10'h000};
			end
		end else if (e == 8'h00 && m == 23'h0) begin
			r.res = {s, 15'h0000};
		end else begin
			// [RL7] denormal source
			r.flg.den = (e == 8'h00);
			sig = {e != 8'h00, m};
			he = (e == 8'h00) ? -10'sd111 : $signed({2'h0, e}) - $signed(hpfc_pkg::HALF_BIAS_D);
			t = 10'sd1 - he;
			// [RL9] tiny results go denormal, never flushed
			sh = (he >= 10'sd1) ? 6'h00 : ((t > 10'sd25) ? 6'h19 : t[5:0]);
			ext = {sig, 26'h0} >> sh;
			keep = ext[49:39];
			g = ext[38];
			st = |ext[37:0];
			// [RL2] rounding decode
			case (rmode)
				hpfc_pkg::RND_NEAREST: inc = g & (st | keep[0]);
				hpfc_pkg::RND_DOWN:    inc = s & (g | st);
				hpfc_pkg::RND_UP:      inc = ~s & (g | st);
				default:              inc = 1'b0;
			endcase
			rnd = {1'b0, keep} + {11'h000, inc};
			// hidden bit in rnd carries into the exponent field
			mag = ((he >= 10'sd1) ? {he[7:0] - 8'h01, 10'h000} : 18'h0) + {6'h00, rnd};
			// [RL8] [RL11] tininess before rounding
			r.flg.unf = (he < 10'sd1);
			r.flg.prc = g | st;
			// [RL10] overflow to signed infinity
			if (mag >= hpfc_pkg::HALF_OVF) begin
				r.flg.ovf = 1'b1;
				r.flg.prc = 1'b1;
				r.res = {s, hpfc_pkg::EXP5_ALL1, 10'h000};
			end else begin
				r.res = {s, mag[14:0]};
			end
		end
		return r;
	endfunction

	// [RL3] pure re-encoding; result is always exact
	function automatic hpfc_pkg::hpfc_single_t h2s(input logic [15:0] x);
		logic       s;
		logic [4:0] e;
		logic [9:0] m;
		logic [4:0] p;
		logic [32:0] t;
		hpfc_pkg::hpfc_single_t r;
		s = x[15];
		e = x[14:10];
		m = x[9:0];
		r = '0;
		p = 5'h00;
		if (e == hpfc_pkg::EXP5_ALL1) begin
			if (m != 10'h0) begin
				r.res = {s, hpfc_pkg::EXP8_ALL1, m, 13'h0000};
				// [RL5] [RL6] quiet it, flag invalid
				if (!m[9]) begin
					r.res[22] = 1'b1;
					r.flg.inv = 1'b1;
				end
			end else begin
				r.res = {s, hpfc_pkg::EXP8_ALL1, 23'h0};
			end
		end else if (e == 5'h00) begin
			if (m != 10'h0) begin
				for (int i = 0; i < 10; i++) begin
					if (m[i]) begin
						p = 5'(i);
					end
				end
				t = {23'h0, m} << (5'd23 - p);
				// [RL7] normalise, denormal flag left alone
				r.res = {s, {3'h0, p} + hpfc_pkg::H2S_DEN_EXP, t[22:0]};
			end else begin
				r.res = {s, 31'h0};
			end
		end else begin
			r.res = {s, {3'h0, e} + hpfc_pkg::H2S_REBIAS, m, 13'h0000};
		end
		return r;
	endfunction

	logic [1:0]            rnd_sel;
	hpfc_pkg::hpfc_flags_t lane_flg    [hpfc_pkg::LANES];
	logic [15:0]           lane_half   [hpfc_pkg::LANES];
	logic [31:0]           lane_single [hpfc_pkg::LANES];
	logic [127:0]          res_d;
	hpfc_pkg::hpfc_flags_t flg_d;
	logic                  raise_d;

	// [RL1] [RL15] only imm bits 2:0 are decoded
	assign rnd_sel = in_imm[hpfc_pkg::IMM_SRC_BIT] ? csr_ctl.rnd_mode
		: in_imm[hpfc_pkg::IMM_RND_LSB +: 2];

	genvar gi;
	generate
		for (gi = 0; gi < hpfc_pkg::LANES; gi++) begin : g_lane
			hpfc_pkg::hpfc_half_t   hv;
			hpfc_pkg::hpfc_single_t sv;
			hpfc_pkg::hpfc_flags_t  f;
			assign hv = s2h(in_data[32*gi +: 32], rnd_sel);
			assign sv = h2s(in_data[16*gi +: 16]);
			always_comb begin
				f = in_to_half ? hv.flg : sv.flg;
				// [RL13] masked denormal with unmasked precision/underflow
				if (f.den && csr_ctl.mask.den && (!csr_ctl.mask.prc || !csr_ctl.mask.unf)) begin
					f.unf = 1'b1;
					f.prc = 1'b1;
				end
			end
			assign lane_flg[gi]    = f;
			assign lane_half[gi]   = hv.res;
			assign lane_single[gi] = sv.res;
		end
	endgenerate

	// halves pack into the low 64 bits; upper half stays zero
	always_comb begin
		res_d = '0;
		for (int i = 0; i < hpfc_pkg::LANES; i++) begin
			if (in_to_half) begin
				res_d[16*i +: 16] = lane_half[i];
			end else begin
				res_d[32*i +: 32] = lane_single[i];
			end
		end
	end

	// [RL15] per-lane flags merged
	always_comb begin
		flg_d = '0;
		for (int i = 0; i < hpfc_pkg::LANES; i++) begin
			flg_d = flg_d | lane_flg[i];
		end
	end

	// [RL6] [RL12] any unmasked flag raises and blocks the write
	assign raise_d = |(flg_d & ~csr_ctl.mask);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_write <= 1'b0;
			out_raise <= 1'b0;
			out_flags <= hpfc_pkg::FLAGS_RESET;
		end else begin
			out_valid <= in_valid;
			out_write <= in_valid & ~raise_d;
			out_raise <= in_valid & raise_d;
			out_flags <= in_valid ? flg_d : hpfc_pkg::FLAGS_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data <= 128'h0;
		end else if (in_valid) begin
			out_data <= res_d;
		end
	end

	// sticky status; a new flag wins over a same-cycle clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_flags <= hpfc_pkg::FLAGS_RESET;
		end else begin
			status_flags <= (status_clr ? hpfc_pkg::FLAGS_RESET : status_flags)
				| (in_valid ? flg_d : hpfc_pkg::FLAGS_RESET);
		end
	end

	// [RL14] feature advertisement
	assign feature_ecx = (32'h1 << hpfc_pkg::FEAT_HALF_CONV_BIT)
		| (32'h1 << hpfc_pkg::FEAT_VEC256_BIT);

	AST_RND_OVERRIDE: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
		in_valid && !in_imm[2] |-> rnd_sel == in_imm[1:0])
		else $error("override rounding not selected");
	AST_FEATURE: assert property (@(posedge clk) disable iff (!rst_n) // [RL14]
		feature_ecx[29] && feature_ecx[28])
		else $error("feature bits missing");
	AST_SNAN_QUIET: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
		in_valid && in_to_half && in_data[126:119] == 8'hff && in_data[118:96] != 23'h0
		&& !in_data[118] |=> out_data[57] && out_data[62:58] == 5'h1f && out_flags.inv)
		else $error("signaling nan not quieted");
	AST_INVALID_NOWRITE: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
		out_valid && out_flags.inv && !$past(csr_ctl.mask.inv) |-> out_raise && !out_write)
		else $error("unmasked invalid still wrote");
	AST_H2S_NO_DEN: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
		in_valid && !in_to_half |=> !out_flags.den)
		else $error("denormal flag set on half-to-single");
	AST_OVF_INF: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
		in_valid && in_to_half && in_data[30:23] >= 8'h8f && in_data[30:23] != 8'hff
		|=> out_data[14:0] == 15'h7c00 && out_flags.ovf)
		else $error("overflow not infinity");
	AST_DEN_RAISE: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
		in_valid && lane_flg[0].den && csr_ctl.mask.den && !csr_ctl.mask.prc
		|=> out_flags.unf && out_flags.prc && out_raise)
		else $error("denormal combination not raised");
	// a clear in the result cycle may legally drop the flag one cycle later
	AST_STICKY: assert property (@(posedge clk) disable iff (!rst_n) // [RL15]
		out_valid && out_flags.prc && !status_clr |-> status_flags.prc [*2])
		else $error("precision flag not accumulated");
	AST_UNDERFLOW: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
		in_valid && in_to_half && in_data[30:23] < 8'h71 && in_data[30:0] != 31'h0
		|=> out_flags.unf)
		else $error("tiny result missed underflow");

endmodule

// ===== verif/hpfc_csr_model.sv
`timescale 1ns/1ps
module hpfc_csr_model (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// pipeline write port
	input  wire logic                wr,
	input  wire hpfc_pkg::hpfc_ctl_t wr_ctl,
	// toward the converter
	output hpfc_pkg::hpfc_ctl_t      csr_ctl
);
	// reset leaves every exception masked and nearest rounding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			csr_ctl <= 7'h1f;
		end else if (wr) begin
			csr_ctl <= wr_ctl;
		end
	end
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [127:0] d;
		logic [4:0]   f;
		logic         w;
		logic         r;
	} hpfc_exp_t;
	logic                  clk, rst_n, in_valid, in_to_half, status_clr, wr;
	logic [7:0]            in_imm;
	logic [127:0]          in_data, out_data;
	hpfc_pkg::hpfc_ctl_t   csr_ctl, wr_ctl;
	logic                  out_valid, out_write, out_raise;
	hpfc_pkg::hpfc_flags_t out_flags, status_flags;
	logic [31:0]           feature_ecx;
	hpfc_exp_t             q[$];
	hpfc_exp_t             e;
	int                    n_mismatch = 0;
	int                    compares = 0;
	logic [15:0]           xp [4] = '{16'h3c02, 16'h3c01, 16'h3c02, 16'h3c01};
	logic [15:0]           xn [4] = '{16'hbc02, 16'hbc02, 16'hbc01, 16'hbc01};

	hpfc_csr_model PART (.clk(clk), .rst_n(rst_n), .wr(wr), .wr_ctl(wr_ctl), .csr_ctl(csr_ctl));
	hpfc_convert DUT (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_to_half(in_to_half),
		.in_imm(in_imm), .in_data(in_data), .csr_ctl(csr_ctl), .status_clr(status_clr),
		.out_valid(out_valid), .out_data(out_data), .out_write(out_write),
		.out_raise(out_raise), .out_flags(out_flags), .status_flags(status_flags),
		.feature_ecx(feature_ecx));

	task automatic chk(string nm, logic [127:0] ex, logic [127:0] got);
		compares++;
		if (got !== ex) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// upper immediate bits get random junk, the converter must ignore them
	task automatic req(logic th, logic [7:0] imm, logic [127:0] d, logic [127:0] xd,
			logic [4:0] xf, logic xr);
		@(posedge clk);
		in_valid <= 1'b1;
		in_to_half <= th;
		in_imm <= {5'($urandom()), imm[2:0]};
		in_data <= d;
		q.push_back('{xd, xf, !xr, xr});
	endtask

	task automatic setcsr(hpfc_pkg::hpfc_ctl_t c);
		@(posedge clk);
		in_valid <= 1'b0;
		wr <= 1'b1;
		wr_ctl <= c;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// outputs stand one cycle, so sample at the edge that ends that cycle
	always @(posedge clk) begin
		if (out_valid === 1'b1) begin
			e = q.pop_front();
			chk("data", e.d, out_data);
			chk("flags", 128'(e.f), 128'(out_flags));
			chk("write", 128'(e.w), 128'(out_write));
			chk("raise", 128'(e.r), 128'(out_raise));
		end
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (2000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end

	initial begin
		{rst_n, in_valid, in_to_half, status_clr, wr, in_imm, in_data, wr_ctl} = '0;
		void'($urandom(32'h2f3f));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		chk("feature", 128'h3000_0000, 128'(feature_ecx));
		for (int r = 0; r < 4; r++) begin
			req(1'b1, 8'(r), {32'h3f803000, 32'h3f800000, 32'hbf803000, 32'h3f803000},
				{64'h0, xp[r], 16'h3c00, xn[r], xp[r]}, 5'h01, 1'b0);
		end
		for (int r = 0; r < 4; r++) begin
			setcsr({2'(r), 5'h1f});
			req(1'b1, 8'(7 - r), {32'h3f803000, 32'h3f800000, 32'hbf803000, 32'h3f803000},
				{64'h0, xp[r], 16'h3c00, xn[r], xp[r]}, 5'h01, 1'b0);
		end
		$display("rounding test done");
		setcsr(7'h1f);
		req(1'b1, 8'h0, {32'h7fa00000, 32'hffc02000, 32'h3f800000, 32'h3f800000},
			{64'h0, 64'h7f00_fe01_3c00_3c00}, 5'h10, 1'b0);
		setcsr(7'h0f);
		req(1'b1, 8'h0, {32'h7fa00000, 32'hffc02000, 32'h3f800000, 32'h3f800000},
			{64'h0, 64'h7f00_fe01_3c00_3c00}, 5'h10, 1'b1);
		setcsr(7'h00);
		req(1'b1, 8'h0, {32'hffc02000, 32'h3f800000, 32'h3f800000, 32'h3f800000},
			{64'h0, 64'hfe01_3c00_3c00_3c00}, 5'h00, 1'b0);
		$display("nan test done");
		setcsr(7'h1f);
		req(1'b1, 8'h0, {32'h47800000, 32'h38000000, 32'h00000001, 32'hc7800000},
			{64'h0, 64'h7c00_0200_0000_fc00}, 5'h0f, 1'b0);
		req(1'b0, 8'h0, {64'h0, 64'h7d00_0001_8000_3c00},
			{128'h7fe00000_33800000_80000000_3f800000}, 5'h10, 1'b0);
		setcsr(7'h1e);
		req(1'b1, 8'h0, {32'h47800000, 32'h3f800000, 32'h3f800000, 32'h00000001},
			{64'h0, 64'h7c00_3c00_3c00_0000}, 5'h0f, 1'b1);
		$display("exception test done");
		@(posedge clk);
		in_valid <= 1'b0;
		repeat (3) @(posedge clk);
		chk("pending", 128'h0, 128'(q.size()));
		chk("status", 128'h1f, 128'(status_flags));
		status_clr <= 1'b1;
		@(posedge clk);
		status_clr <= 1'b0;
		@(posedge clk);
		chk("status cleared", 128'h0, 128'(status_flags));
		$display("status test done");
		complete_run();
	end
endmodule
